// [trig_pkg.sv]
/*
 Shared constants for the trigger layer link controller: register
 offsets, field positions, reset values, encodings and timing counts.
 Assumes a single 50 MHz clock domain and the plain register port.
*/
package trig_pkg;
   // Clock rate in hertz
   localparam int CLK_HZ = 50000000;
   // Output trigger pulse length in cycles
   localparam int PULSE_CYCLES = 2;
   // Register offsets (word index on the plain port)
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_LINES_ARM = 4'h1;
   localparam logic [3:0] OFF_LINES_SCAN = 4'h2;
   localparam logic [3:0] OFF_LINES_MEAS = 4'h3;
   localparam logic [3:0] OFF_DATE = 4'h4;
   localparam logic [3:0] OFF_TIME = 4'h5;
   localparam logic [3:0] OFF_STATUS = 4'h6;
   localparam logic [3:0] OFF_SEQ_CMD = 4'h7;
   // Control register fields
   localparam int CTRL_BYP_ARM = 0;
   localparam int CTRL_BYP_SCAN = 1;
   localparam int CTRL_BYP_MEAS = 2;
   localparam int CTRL_SHARED = 3;
   localparam int CTRL_SRC_LSB = 4;
   localparam int CTRL_CNT_LSB = 10;
   // Source code per layer (2 bits each)
   localparam logic [1:0] SRC_IMM = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_LINK = 2'h2;
   localparam logic [1:0] SRC_OTHER = 2'h3;
   // Line select fields: input in [2:0], output in [6:4], shared [10:8]
   localparam int LN_IN_LSB = 0;
   localparam int LN_OUT_LSB = 4;
   localparam int LN_SH_LSB = 8;
   localparam logic [2:0] LINE_MIN = 3'h1;
   localparam logic [2:0] LINE_MAX = 3'h6;
   localparam logic [2:0] RST_IN_LINE = 3'h1;
   localparam logic [2:0] RST_OUT_LINE = 3'h2;
   // Date fields: year [27:16], month [11:8], day [4:0]
   localparam logic [11:0] YEAR_MIN = 12'h7CA;
   localparam logic [11:0] YEAR_MAX = 12'h82D;
   localparam logic [3:0] MONTH_MAX = 4'hC;
   localparam logic [4:0] DAY_MAX = 5'h1F;
   // Time fields: hour [28:24], minute [21:16], hundredths [12:0]
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [5:0] MIN_MAX = 6'h3B;
   localparam logic [12:0] CS_MAX = 13'h176F;
   localparam logic [31:0] RST_DATE = 32'h07CA0101;
   // Sequence command bits
   localparam int SEQ_ARM = 0;
   localparam int SEQ_ABORT = 1;
   localparam int SEQ_CLR_ERR = 2;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARM, ST_SCAN, ST_MEAS, ST_ACT
   } layer_t;
   typedef enum logic [1:0] {SQ_IDLE, SQ_ARMED, SQ_RUN} seq_t;
endpackage

// [trig_pulse.sv]
/*
 Fixed length pulse generator for one output trigger.
 Assumes the fire input is a one-cycle request.
*/
`timescale 1ns/10ps
module trig_pulse #(
   parameter int LEN = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Request and pulse
   input wire logic fire,
   output logic pulse
);
   // Remaining cycles of the pulse
   logic [7:0] cnt_reg;
   // Load on request, count down otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 8'h00;
      end else if (fire) begin
         cnt_reg <= 8'(LEN);
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
   // Pulse is high while counting
   assign pulse = (cnt_reg != 8'h00);
endmodule

// [trig_layer_ctrl.sv]
/*
 Three layer trigger controller with source bypass, link line
 selection, calendar event settings and test sequence arm/abort.
 Assumes a single clock, synchronous inputs, and a host on the plain
 register port that never issues read and write together.
*/
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module trig_layer_ctrl
   import trig_pkg::*;
#(
   parameter int CNT_W = 3,
   parameter int DELAY_CYCLES = 4
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Trigger link lines, index 0 is line 1
   input wire logic [5:0] LINK_IN,
   output logic [5:0] LINK_OUT,
   output logic [5:0] LINK_OE,
   // Other event sources and completion
   input wire logic EXT_TRIG,
   input wire logic START_EVENT,
   input wire logic ACTION_DONE,
   output logic ACTION_GO,
   output logic COMPLETION_PULSE_OUTPUT,
   // Status
   output logic SEQ_RUNNING,
   output logic CFG_ERROR
);
   import trig_pkg::*;

   // Configuration registers
   logic [31:0] ctrl_reg;
   logic [2:0] in_line_reg [3];
   logic [2:0] out_line_reg [3];
   logic [2:0] shared_line_reg;
   logic [31:0] date_reg;
   logic [31:0] time_reg;
   logic err_reg;
   // Sequencer and test sequence state
   layer_t lay_reg, lay_next;
   seq_t seq_reg;
   logic [2:0] byp_ok_reg; // Bypass still allowed per layer
   logic [CNT_W-1:0] pass_reg [3];
   logic [7:0] dly_reg;
   logic [31:0] rdata_reg;

   // Write decode
   wire wr_ctrl = WR && ADDR == OFF_CTRL;
   wire wr_date = WR && ADDR == OFF_DATE;
   wire wr_time = WR && ADDR == OFF_TIME;
   wire wr_seq = WR && ADDR == OFF_SEQ_CMD;
   wire [2:0] new_in = WDATA[LN_IN_LSB+:3];
   wire [2:0] new_out = WDATA[LN_OUT_LSB+:3];
   wire [2:0] new_sh = WDATA[LN_SH_LSB+:3];
   wire shared_mode = ctrl_reg[CTRL_SHARED];

   // Calendar checks; days per month kept simple, leap years honored
   wire [11:0] yr = WDATA[27:16];
   wire [3:0] mo = WDATA[11:8];
   wire [4:0] dy = WDATA[4:0];
   wire leap = (yr[1:0] == 2'h0);
   wire [4:0] mdays = (mo == 4'h2) ? (leap ? 5'h1D : 5'h1C) :
      (mo == 4'h4 || mo == 4'h6 || mo == 4'h9 || mo == 4'hB) ? 5'h1E
      : DAY_MAX;
   wire date_ok = yr >= YEAR_MIN && yr <= YEAR_MAX && mo != 4'h0 &&
      mo <= MONTH_MAX && dy != 5'h00 && dy <= mdays;
   wire time_ok = WDATA[28:24] <= HOUR_MAX && WDATA[21:16] <= MIN_MAX
      && WDATA[12:0] <= CS_MAX;

   // Per-layer line decode and events
   logic [2:0] line_bad_in, line_bad_out, src_ev, bypass_on;
   logic [2:0] layer_sel;
   logic [5:0] out_fire [3];
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_layer
         wire [1:0] src = ctrl_reg[CTRL_SRC_LSB+2*g+:2];
         wire wr_ln = WR && ADDR == OFF_LINES_ARM + 4'(g);
         wire range_in = new_in >= LINE_MIN && new_in <= LINE_MAX;
         wire range_out = new_out >= LINE_MIN && new_out <= LINE_MAX;
         // Measure layer in shared mode uses the one shared line
         wire use_sh = (g == 2) && shared_mode;
         wire [2:0] il = use_sh ? shared_line_reg : in_line_reg[g];
         wire [2:0] ol = use_sh ? shared_line_reg : out_line_reg[g];
         // Conflicts are checked against the line held now
         assign line_bad_in[g] = wr_ln && (new_in == out_line_reg[g]
            || !range_in);
         assign line_bad_out[g] = wr_ln && (new_out == in_line_reg[g]
            || !range_out);
         // Selected source event of this layer
         assign src_ev[g] = (src == SRC_IMM) ||
            (src == SRC_EXT && EXT_TRIG) ||
            (src == SRC_LINK && LINK_IN[il - 3'h1]);
         // Bypass only for external or link source, first pass only
         assign bypass_on[g] = ctrl_reg[CTRL_BYP_ARM+g] &&
            byp_ok_reg[g] && (src == SRC_EXT || src == SRC_LINK);
         // Route leave-layer pulse to link line or completion
         assign out_fire[g] = (layer_sel[g] && src == SRC_LINK) ?
            6'(1) << (ol - 3'h1) : 6'h00;
         // Line selection registers
         always_ff @(posedge CLK) begin
            if (RST) begin
               in_line_reg[g] <= RST_IN_LINE;
               out_line_reg[g] <= RST_OUT_LINE;
            end else if (wr_ln) begin
               if (!line_bad_in[g]) begin
                  in_line_reg[g] <= new_in;
               end
               if (!line_bad_out[g]) begin
                  out_line_reg[g] <= new_out;
               end
            end
         end
      end
   endgenerate

   // Layer exit strobes: arm/scan only with bypass enabled
   wire leave_arm = lay_reg == ST_ARM && lay_next != ST_ARM;
   wire leave_scan = lay_reg == ST_SCAN && lay_next != ST_SCAN;
   wire meas_done = lay_reg == ST_ACT && ACTION_DONE;
   assign layer_sel[0] = leave_arm && ctrl_reg[CTRL_BYP_ARM];
   assign layer_sel[1] = leave_scan && ctrl_reg[CTRL_BYP_SCAN];
   assign layer_sel[2] = meas_done;
   wire [5:0] link_fire = out_fire[0] | out_fire[1] | out_fire[2];
   wire [2:0] src_is_link;
   assign src_is_link[0] = ctrl_reg[CTRL_SRC_LSB+:2] == SRC_LINK;
   assign src_is_link[1] = ctrl_reg[CTRL_SRC_LSB+2+:2] == SRC_LINK;
   assign src_is_link[2] = ctrl_reg[CTRL_SRC_LSB+4+:2] == SRC_LINK;
   wire comp_fire = |(layer_sel & ~src_is_link);

   // Pass counts per layer from the control register
   wire [CNT_W-1:0] cnt_arm = ctrl_reg[CTRL_CNT_LSB+:CNT_W];
   wire [CNT_W-1:0] cnt_scan = ctrl_reg[CTRL_CNT_LSB+CNT_W+:CNT_W];
   wire [CNT_W-1:0] cnt_meas = ctrl_reg[CTRL_CNT_LSB+2*CNT_W+:CNT_W];
   wire delay_done = dly_reg == 8'h00;

   // Layer sequencer: arm, scan, measure, then device action
   always_comb begin
      lay_next = lay_reg;
      case (lay_reg)
         ST_IDLE: begin
            if (seq_reg == SQ_RUN) begin
               lay_next = ST_ARM;
            end
         end
         ST_ARM: begin
            // Arm layer has no delay
            if (bypass_on[0] || src_ev[0]) begin
               lay_next = ST_SCAN;
            end
         end
         ST_SCAN: begin
            // Bypass skips both wait and delay
            if (bypass_on[1] || (src_ev[1] && delay_done)) begin
               lay_next = ST_MEAS;
            end
         end
         ST_MEAS: begin
            if (bypass_on[2] || (src_ev[2] && delay_done)) begin
               lay_next = ST_ACT;
            end
         end
         ST_ACT: begin
            if (ACTION_DONE) begin
               if (pass_reg[2] + 1'b1 < cnt_meas) begin
                  lay_next = ST_MEAS;
               end else if (pass_reg[1] + 1'b1 < cnt_scan) begin
                  lay_next = ST_SCAN;
               end else if (pass_reg[0] + 1'b1 < cnt_arm) begin
                  lay_next = ST_ARM;
               end else begin
                  lay_next = ST_IDLE;
               end
            end
         end
         default: lay_next = ST_IDLE;
      endcase
      // Abort overrides any layer
      if (seq_reg != SQ_RUN) begin
         lay_next = ST_IDLE;
      end
   end

   // Sequencer state, pass counters and bypass eligibility
   always_ff @(posedge CLK) begin
      if (RST) begin
         lay_reg <= ST_IDLE;
         byp_ok_reg <= 3'h7;
         for (int i = 0; i < 3; i++) begin
            pass_reg[i] <= '0;
         end
      end else begin
         lay_reg <= lay_next;
         if (lay_next == ST_IDLE) begin
            byp_ok_reg <= 3'h7;
            for (int i = 0; i < 3; i++) begin
               pass_reg[i] <= '0;
            end
         end else if (meas_done) begin
            // Repeat passes lose bypass; outer return re-arms inner
            if (lay_next == ST_MEAS) begin
               byp_ok_reg[2] <= 1'b0;
               pass_reg[2] <= pass_reg[2] + 1'b1;
            end else if (lay_next == ST_SCAN) begin
               byp_ok_reg[1] <= 1'b0;
               byp_ok_reg[2] <= 1'b1;
               pass_reg[1] <= pass_reg[1] + 1'b1;
               pass_reg[2] <= '0;
            end else begin
               byp_ok_reg[0] <= 1'b0;
               byp_ok_reg[2:1] <= 2'h3;
               pass_reg[0] <= pass_reg[0] + 1'b1;
               pass_reg[1] <= '0;
               pass_reg[2] <= '0;
            end
         end
      end
   end

   // Layer delay counter, loaded on entry to scan or measure
   always_ff @(posedge CLK) begin
      if (RST) begin
         dly_reg <= 8'h00;
      end else if (lay_next != lay_reg) begin
         dly_reg <= 8'(DELAY_CYCLES);
      end else if (!delay_done) begin
         dly_reg <= dly_reg - 8'h01;
      end
   end

   // Test sequence arm, start and abort
   always_ff @(posedge CLK) begin
      if (RST) begin
         seq_reg <= SQ_IDLE;
      end else if (wr_seq && WDATA[SEQ_ABORT]) begin
         seq_reg <= SQ_IDLE;
      end else if (wr_seq && WDATA[SEQ_ARM]) begin
         seq_reg <= SQ_ARMED;
      end else if (seq_reg == SQ_ARMED && START_EVENT) begin
         seq_reg <= SQ_RUN;
      end else if (seq_reg == SQ_RUN && lay_reg == ST_ACT &&
            lay_next == ST_IDLE) begin
         seq_reg <= SQ_IDLE;
      end
   end

   // Control, shared line, date and time registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl_reg <= 32'h00000000;
         shared_line_reg <= RST_IN_LINE;
         date_reg <= RST_DATE;
         time_reg <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= WDATA;
         end
         if (WR && ADDR == OFF_LINES_MEAS && new_sh >= LINE_MIN &&
               new_sh <= LINE_MAX) begin
            shared_line_reg <= new_sh;
         end
         if (wr_date && date_ok) begin
            date_reg <= {4'h0, yr, 3'h0, 1'b0, mo, 3'h0, dy};
         end
         if (wr_time && time_ok) begin
            time_reg <= WDATA & 32'h1F3F1FFF;
         end
      end
   end

   // Sticky error; a new error in the clear cycle wins
   wire err_set = |line_bad_in || |line_bad_out ||
      (wr_date && !date_ok) || (wr_time && !time_ok);
   always_ff @(posedge CLK) begin
      if (RST) begin
         err_reg <= 1'b0;
      end else if (err_set) begin
         err_reg <= 1'b1;
      end else if (wr_seq && WDATA[SEQ_CLR_ERR]) begin
         err_reg <= 1'b0;
      end
   end

   // Read mux, data registered one cycle later
   wire [1:0] rd_idx = 2'(ADDR - OFF_LINES_ARM);
   wire [31:0] rd_mux =
      (ADDR == OFF_CTRL) ? ctrl_reg :
      (ADDR >= OFF_LINES_ARM && ADDR <= OFF_LINES_MEAS) ?
         {21'h0, (rd_idx == 2'h2) ? shared_line_reg : 3'h0, 1'b0,
         out_line_reg[rd_idx], 1'b0, in_line_reg[rd_idx]} :
      (ADDR == OFF_DATE) ? date_reg :
      (ADDR == OFF_TIME) ? time_reg :
      (ADDR == OFF_STATUS) ? {23'h0, 3'(lay_reg), 3'h0, err_reg,
         2'(seq_reg)} : 32'h00000000;
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= RD ? rd_mux : 32'h00000000;
      end
   end
   assign RDATA = rdata_reg;

   // Output pulse stretchers, one per link line plus completion
   logic [6:0] pulses;
   generate
      for (g = 0; g < 7; g++) begin : g_pulse
         trig_pulse #(.LEN(PULSE_CYCLES)) u_pulse (
            .clk(CLK),
            .rst(RST),
            .fire(g < 6 ? link_fire[g % 6] : comp_fire),
            .pulse(pulses[g])
         );
      end
   endgenerate
   assign LINK_OUT = pulses[5:0];
   assign LINK_OE = pulses[5:0];
   assign COMPLETION_PULSE_OUTPUT = pulses[6];
   assign ACTION_GO = lay_reg == ST_ACT;
   assign SEQ_RUNNING = seq_reg == SQ_RUN;
   assign CFG_ERROR = err_reg;

   // Conflicting input write never changes the input line
   property p_in_keep;
      @(posedge CLK) disable iff (RST)
      line_bad_in[0] |=> in_line_reg[0] == $past(in_line_reg[0]);
   endproperty
   a_in_keep: assert property (p_in_keep)
      else $error("input line changed on conflict");
   property p_out_keep;
      @(posedge CLK) disable iff (RST)
      line_bad_out[1] |=> out_line_reg[1] == $past(out_line_reg[1]);
   endproperty
   a_out_keep: assert property (p_out_keep)
      else $error("output line changed on conflict");
   property p_err_sticky;
      @(posedge CLK) disable iff (RST)
      err_set |=> CFG_ERROR;
   endproperty
   a_err_sticky: assert property (p_err_sticky)
      else $error("error flag not set");
   property p_meas_pulse;
      @(posedge CLK) disable iff (RST)
      meas_done && !src_is_link[2] |=> COMPLETION_PULSE_OUTPUT [*2];
   endproperty
   a_meas_pulse: assert property (p_meas_pulse)
      else $error("measure trigger missing");
   property p_no_pulse;
      @(posedge CLK) disable iff (RST)
      leave_arm && !ctrl_reg[CTRL_BYP_ARM] |-> !layer_sel[0];
   endproperty
   a_no_pulse: assert property (p_no_pulse)
      else $error("arm trigger without bypass");
   property p_abort;
      @(posedge CLK) disable iff (RST)
      wr_seq && WDATA[SEQ_ABORT] |=> !SEQ_RUNNING ##1 lay_reg == ST_IDLE;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort did not stop sequence");
   property p_start;
      @(posedge CLK) disable iff (RST)
      $rose(SEQ_RUNNING) |-> $past(START_EVENT);
   endproperty
   a_start: assert property (p_start)
      else $error("sequence started without event");
   property p_wait;
      @(posedge CLK) disable iff (RST)
      lay_reg == ST_ARM && !bypass_on[0] && !src_ev[0] && SEQ_RUNNING
      && !(wr_seq && WDATA[SEQ_ABORT]) |=> lay_reg == ST_ARM;
   endproperty
   a_wait: assert property (p_wait)
      else $error("arm layer left without event");
endmodule

// [trig_link_peer.sv]
/*
 Peer instrument on the six shared trigger link lines.
 Assumes lines idle low through a pull-down and high means trigger.
*/
`timescale 1ns/10ps
module trig_link_peer #(
   parameter int LEN = 2
) (
   // Clock
   input wire logic clk,
   // Observed levels, bit 6 is the completion output
   input wire logic [6:0] mon,
   // Our drive onto the link
   output logic [5:0] drive
);
   int rises[7]; // Rising edges seen per line
   int run[7]; // Length of the current high run
   int bad_len; // Pulses of the wrong length
   logic [6:0] prev = 7'h00; // Levels one cycle ago
   initial drive = 6'h00;
   // Count pulses and measure each one
   always @(posedge clk) begin
      for (int k = 0; k < 7; k++) begin
         if (mon[k]) begin
            run[k] = run[k] + 1;
         end else if (run[k] != 0) begin
            if (run[k] != LEN) bad_len = bad_len + 1;
            run[k] = 0;
         end
         if (mon[k] && !prev[k]) rises[k] = rises[k] + 1;
      end
      prev <= mon;
   end
   // Counts start afresh for each sequence
   task automatic clr();
      for (int k = 0; k < 7; k++) rises[k] = 0;
      bad_len = 0;
   endtask
   // Slow answer: wait, then one trigger; the pull-down takes over
   task automatic fire(input int line, input int wait_c);
      repeat (wait_c) @(posedge clk);
      drive[line-1] <= 1'b1;
      repeat (LEN) @(posedge clk);
      drive[line-1] <= 1'b0;
   endtask
endmodule

// [trigger_layer_link_control_tb_top.sv]
/*
 Self-checking bench for the trigger layer controller.
 Assumes the peer model on the link and the package constants.
*/
`timescale 1ns/10ps
module trigger_layer_link_control_tb_top;
   import trig_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, dv, tv;
   logic [31:0] m_date = RST_DATE, m_time = 32'h0; // Expected calendar
   logic [5:0] link_out, link_oe, drive;
   logic ext_trig = 1'b0, start_ev = 1'b0, act_done = 1'b0;
   logic act_go, comp, running, cfg_err;
   int n_mismatch = 0, checked = 0, cyc = 0, gcnt = 0;
   int k, y, m, dy, h, mi, cs;
   logic [2:0] ni, no, sh, m_sh = 3'h1; // Line fields and shared model
   logic [2:0] m_in[3] = '{3'h1, 3'h1, 3'h1};
   logic [2:0] m_out[3] = '{3'h2, 3'h2, 3'h2};
   bit ei, eo, dok, tok;
   int cy[8] = '{2093, 2094, 1993, 1994, 1994, 1996, 1995, 1994};
   int cmo[8] = '{12, 1, 5, 13, 2, 2, 4, 1};
   int cdy[8] = '{31, 1, 5, 1, 29, 29, 31, 0};
   int ch[4] = '{23, 24, 0, 0};
   int cmi[4] = '{59, 0, 60, 0};
   int ccs[4] = '{5999, 0, 0, 6000};
   always #10 clk = ~clk;
   // Link wire: our own enabled drive plus the peer
   trig_layer_ctrl #(.CNT_W(3), .DELAY_CYCLES(4)) i_dut (
      .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .LINK_IN(drive | (link_oe & link_out)),
      .LINK_OUT(link_out), .LINK_OE(link_oe), .EXT_TRIG(ext_trig),
      .START_EVENT(start_ev), .ACTION_DONE(act_done),
      .ACTION_GO(act_go), .COMPLETION_PULSE_OUTPUT(comp),
      .SEQ_RUNNING(running), .CFG_ERROR(cfg_err));
   trig_link_peer #(.LEN(PULSE_CYCLES)) i_peer (.clk(clk),
      .mon({comp, link_oe & link_out}), .drive(drive));
   // Device action finishes four cycles after it starts
   always @(posedge clk) begin
      gcnt <= act_go ? gcnt + 1 : 0;
      act_done <= act_go && gcnt == 3;
   end
   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [3:0] a,
         input logic [31:0] mask, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata & mask);
      if (mask == 32'h4) chk("error pin", exp >> 2, {31'h0, cfg_err});
      @(posedge clk);
   endtask
   // One-cycle start or external event
   task automatic strobe(input bit ext);
      if (ext) ext_trig <= 1'b1;
      else start_ev <= 1'b1;
      @(posedge clk);
      ext_trig <= 1'b0;
      start_ev <= 1'b0;
      @(posedge clk);
   endtask
   // Armed only once the previous sequence is over
   task automatic run_seq(input logic [31:0] ctl);
      wr_reg(OFF_CTRL, ctl);
      i_peer.clr();
      wr_reg(OFF_SEQ_CMD, 32'h1);
      strobe(1'b0); // No polarity sequence, so no hold-off
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clk);
      while (running !== 1'b0 && n < 800) begin
         @(negedge clk);
         n++;
      end
      chk("sequence end", 32'h0, {31'h0, running});
      // Let the last pulse finish and be counted by the peer
      repeat (4) @(posedge clk);
   endtask
   function automatic bit date_ok(int y, int m, int d);
      int dim;
      dim = (m == 2) ? ((y % 4 == 0) ? 29 : 28) :
         (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
      return y >= 1994 && y <= 2093 && m >= 1 && m <= 12 && d >= 1 &&
         d <= dim;
   endfunction
   // Main sequence
   initial begin
      void'($urandom(67));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk("ctrl", OFF_CTRL, '1, 32'h0);
      rd_chk("arm lines", OFF_LINES_ARM, '1, 32'h21);
      rd_chk("meas lines", OFF_LINES_MEAS, '1, 32'h121);
      rd_chk("date", OFF_DATE, '1, RST_DATE);
      rd_chk("unmapped", 4'hF, '1, 32'h0);
      $display("test reset finished");
      // Arm via link on line 3, scan via external: both bypassed
      wr_reg(OFF_LINES_ARM, 32'h31);
      wr_reg(OFF_LINES_SCAN, 32'h51);
      m_out[0] = 3'h3;
      m_out[1] = 3'h5;
      run_seq(32'h63);
      wait_idle();
      chk("arm link pulse", 1, i_peer.rises[2]);
      chk("scan link line", 0, i_peer.rises[4]);
      chk("completion pulses", 2, i_peer.rises[6]);
      chk("pulse length", 0, i_peer.bad_len);
      $display("test bypass finished");
      // No bypass: held until the external event; abort on the way
      wr_reg(OFF_CTRL, 32'h10);
      wr_reg(OFF_SEQ_CMD, 32'h1);
      repeat (8) @(posedge clk);
      rd_chk("armed", OFF_STATUS, 32'h3, 32'h1);
      i_peer.clr();
      strobe(1'b0);
      repeat (30) @(posedge clk);
      rd_chk("held", OFF_STATUS, 32'h3, 32'h2);
      chk("early pulse", 0, i_peer.rises[6]);
      wr_reg(OFF_SEQ_CMD, 32'h2);
      strobe(1'b0);
      rd_chk("aborted", OFF_STATUS, 32'h3, 32'h0);
      run_seq(32'h10);
      repeat (5) @(posedge clk);
      strobe(1'b1);
      wait_idle();
      chk("measure pulse only", 1, i_peer.rises[6]);
      $display("test wait finished");
      // Two arm passes: bypass on the first of each sequence only
      for (int r = 0; r < 2; r++) begin
         run_seq(32'h821);
         repeat (80) @(posedge clk);
         chk("first pass", 1, i_peer.rises[2]);
         i_peer.fire(1, 3);
         wait_idle();
         chk("second pass", 2, i_peer.rises[2]);
         chk("measure pulses", 2, i_peer.rises[6]);
      end
      $display("test repeat finished");
      // Line selections: conflicts first, then random
      for (int i = 0; i < 14; i++) begin
         k = (i < 6) ? i % 3 : $urandom_range(2, 0);
         ni = (i < 3) ? m_out[k] : (i < 6) ? m_in[k] : 3'($urandom_range(7, 0));
         no = (i < 6) ? m_in[k] : 3'($urandom_range(7, 0));
         if (i < 3) no = m_out[k];
         sh = 3'($urandom_range(6, 1));
         ei = ni < 1 || ni > 6 || ni == m_out[k];
         eo = no < 1 || no > 6 || no == m_in[k];
         wr_reg(OFF_SEQ_CMD, 32'h4);
         wr_reg(OFF_LINES_ARM + 4'(k), {21'h0, sh, 1'b0, no, 1'b0, ni});
         if (!ei) m_in[k] = ni;
         if (!eo) m_out[k] = no;
         if (k == 2) m_sh = sh;
         rd_chk("lines", OFF_LINES_ARM + 4'(k), '1, {21'h0,
            (k == 2) ? m_sh : 3'h0, 1'b0, m_out[k], 1'b0, m_in[k]});
         rd_chk("error", OFF_STATUS, 32'h4, {29'h0, ei | eo, 2'h0});
      end
      $display("test lines finished");
      // Shared line: measure waits on and answers on one line
      run_seq(32'h208);
      repeat (20) @(posedge clk);
      i_peer.fire(int'(m_sh), 3);
      wait_idle();
      chk("shared line pulse", 1, i_peer.rises[m_sh - 3'h1]);
      chk("shared no completion", 0, i_peer.rises[6]);
      $display("test shared finished");
      // Calendar date and time: edges first, then random
      for (int i = 0; i < 16; i++) begin
         y = (i < 8) ? cy[i % 8] : $urandom_range(2097, 1990);
         m = (i < 8) ? cmo[i % 8] : $urandom_range(13, 0);
         dy = (i < 8) ? cdy[i % 8] : $urandom_range(31, 0);
         h = (i < 4) ? ch[i % 4] : $urandom_range(25, 0);
         mi = (i < 4) ? cmi[i % 4] : $urandom_range(61, 0);
         cs = (i < 4) ? ccs[i % 4] : $urandom_range(6100, 0);
         dok = date_ok(y, m, dy);
         tok = h <= 23 && mi <= 59 && cs <= 5999;
         dv = {4'h0, 12'(y), 4'h0, 4'(m), 3'h0, 5'(dy)};
         tv = {3'h0, 5'(h), 2'h0, 6'(mi), 3'h0, 13'(cs)};
         wr_reg(OFF_SEQ_CMD, 32'h4);
         wr_reg(OFF_DATE, dv);
         wr_reg(OFF_TIME, tv);
         if (dok) m_date = dv;
         if (tok) m_time = tv;
         rd_chk("date", OFF_DATE, '1, m_date);
         rd_chk("time", OFF_TIME, '1, m_time);
         rd_chk("error", OFF_STATUS, 32'h4, {29'h0, !(dok && tok), 2'h0});
      end
      $display("test calendar finished");
      give_verdict();
   end
endmodule
